//--- netcfg_pkg.sv
// Package: register map, field layout and constants for the network config block
`default_nettype none
package netcfg_pkg;
  // APB register byte offsets
  localparam logic [7:0] OFF_CONFIG  = 8'h00; // Latched switch settings (RO)
  localparam logic [7:0] OFF_REMOTE  = 8'h04; // Remote input word (RW)
  localparam logic [7:0] OFF_CMD     = 8'h08; // Decoded command state (RO)
  localparam logic [7:0] OFF_STATUS  = 8'h0C; // Sticky events, read clears
  localparam logic [7:0] OFF_MASK    = 8'h10; // Interrupt mask (RW)
  localparam logic [7:0] OFF_LINKERR = 8'h14; // Link error report (W)
  // Remote word bit positions
  localparam int B_OPSEL = 0;  // 3 bits
  localparam int B_START = 3;
  localparam int B_HOME = 4;
  localparam int B_STOP = 5;
  localparam int B_FREE = 6;
  localparam int B_DSEL = 8;   // 3 bits
  localparam int B_SEQUENTIAL_START = 11;
  localparam int B_JOGP = 12;
  localparam int B_JOGM = 13;
  localparam int B_FORWARD = 14;
  localparam int B_REVERSE = 15;
  // Baud setting that selects the converter rate, and that rate
  localparam logic [3:0] BAUD_CONV = 4'h7;
  localparam int BAUD_CONV_BPS = 625000;
  localparam int CLK_HZ = 40000000;
  // Cycles per bit, rounded down
  localparam logic [7:0] BAUD_DIV = 8'(CLK_HZ / BAUD_CONV_BPS);
  localparam logic [7:0] BAUD_DIV_OTHER = 8'hFF; // Fallback divider
  // Status bits
  localparam int NEV = 4;
  localparam int EV_LINKERR = 0;
  localparam int EV_MOTION = 1;
  localparam int EV_STOPPED = 2;
  localparam int EV_CFG = 3;
  localparam logic [NEV-1:0] MASK_RST = 4'h0;
  localparam logic [15:0] REMOTE_RST = 16'h0000;
  localparam logic [31:0] RD_UNMAPPED = 32'h00000000;

  // Latched switch settings
  typedef struct packed {
    logic       term_enable;
    logic       term_mismatch;
    logic [3:0] baud;
    logic       to_converter;
    logic       range16;
    logic [3:0] node_addr;
  } cfg_t;

  // Decoded operation commands
  typedef struct packed {
    logic [2:0] op_sel;
    logic [2:0] dsel;
    logic       start;
    logic       home;
    logic       sequential_start;
    logic       jog_plus;
    logic       jog_minus;
    logic       forward;
    logic       reverse;
    logic       free;
  } cmd_t;

  // Init state machine
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_LATCH = 2'b01,
    ST_RUN   = 2'b10
  } init_st_t;
endpackage : netcfg_pkg
`default_nettype wire

//--- network_remote_io_config.sv
// Network configuration and remote input decoder with APB registers
// Behaviour
// - Switch off means converter attached
// - Node address from rotary plus range
// - Setting 7 gives 625000 bps link
// - Switches sampled only at power-up
// - Both termination switches on enable 120 ohm
// - Remote word decoded by fixed bit map
// - Forward bit runs continuously while held
// - Link error lights error indicator
//
// Decided for this implementation: the address map and the APB slave port.
`default_nettype none
module network_remote_io_config (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [31:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic LINK_PARTNER_SELECT,
  input wire logic ADDRESS_RANGE_SELECT,
  input wire logic [3:0] ADDRESS_ROTARY_SWITCH,
  input wire logic [3:0] BAUD_RATE_SWITCH,
  input wire logic TERM_SWITCH_1,
  input wire logic TERM_SWITCH_2,
  input wire logic LINK_ERROR_IN,
  output logic TERM_ENABLE,
  output logic LINK_ERROR_LED,
  output logic BAUD_TICK,
  output logic FORWARD_CONTINUOUS,
  output logic REVERSE_CONTINUOUS,
  output logic JOG_PLUS,
  output logic JOG_MINUS,
  output logic MOTION_STOP,
  output logic IRQ
);
  // Settings captured once after reset release
  netcfg_pkg::cfg_t cfg_r;
  netcfg_pkg::init_st_t st_r;
  // Remote input word written by the converter side
  logic [15:0] remote_r;
  // Sticky events and mask
  logic [netcfg_pkg::NEV-1:0] status_r;
  logic [netcfg_pkg::NEV-1:0] status_nxt;
  logic [netcfg_pkg::NEV-1:0] mask_r;
  // Bit clock divider
  logic [7:0] div_r;
  logic [7:0] div_nxt;
  logic err_r;
  logic stop_prev_r;
  logic motion_prev_r;

  // APB decode
  wire acc = PSEL && PENABLE;
  wire wr = acc && PWRITE;
  wire rd = acc && !PWRITE;
  wire [7:0] off = PADDR[7:0];
  wire mapped = (PADDR[31:8] == 24'h000000) && (off[1:0] == 2'b00) &&
    (off <= netcfg_pkg::OFF_LINKERR);
  wire wr_remote = wr && mapped && off == netcfg_pkg::OFF_REMOTE;
  wire wr_mask = wr && mapped && off == netcfg_pkg::OFF_MASK;
  wire wr_linkerr = wr && mapped && off == netcfg_pkg::OFF_LINKERR;
  wire rd_status = rd && mapped && off == netcfg_pkg::OFF_STATUS;

  netcfg_pkg::cmd_t cmd;
  assign cmd.op_sel = remote_r[netcfg_pkg::B_OPSEL +: 3];
  assign cmd.dsel = remote_r[netcfg_pkg::B_DSEL +: 3];
  assign cmd.start = remote_r[netcfg_pkg::B_START];
  assign cmd.home = remote_r[netcfg_pkg::B_HOME];
  assign cmd.sequential_start = remote_r[netcfg_pkg::B_SEQUENTIAL_START];
  assign cmd.jog_plus = remote_r[netcfg_pkg::B_JOGP];
  assign cmd.jog_minus = remote_r[netcfg_pkg::B_JOGM];
  assign cmd.forward = remote_r[netcfg_pkg::B_FORWARD];
  assign cmd.reverse = remote_r[netcfg_pkg::B_REVERSE];
  assign cmd.free = remote_r[netcfg_pkg::B_FREE];
  // Stop bit kept apart, it gates every motion request
  wire stop_in = remote_r[netcfg_pkg::B_STOP];
  // Only a converter-attached, running node accepts remote motion
  wire live = (st_r == netcfg_pkg::ST_RUN) && cfg_r.to_converter;

  wire go = live && !stop_in;
  // forward held while bit stays set
  // Opposing requests cancel, so the motor never gets both
  wire forward_nxt = go && cmd.forward && !cmd.reverse;
  wire reverse_nxt = go && cmd.reverse && !cmd.forward;
  wire jogp_nxt = go && cmd.jog_plus && !cmd.jog_minus;
  wire jogm_nxt = go && cmd.jog_minus && !cmd.jog_plus;
  wire moving = forward_nxt || reverse_nxt || jogp_nxt || jogm_nxt;

  wire err_nxt = LINK_ERROR_IN || (wr_linkerr && PWDATA[0]) ||
    (live && cfg_r.term_mismatch);

  wire [7:0] div_load = (cfg_r.baud == netcfg_pkg::BAUD_CONV) ?
    netcfg_pkg::BAUD_DIV : netcfg_pkg::BAUD_DIV_OTHER;
  wire tick = (st_r == netcfg_pkg::ST_RUN) && (div_r == 8'h01);
  assign div_nxt = (st_r != netcfg_pkg::ST_RUN || div_r == 8'h01) ?
    div_load : div_r - 8'h01;

  // Event sources; set wins over read clear
  wire [netcfg_pkg::NEV-1:0] ev;
  assign ev[netcfg_pkg::EV_LINKERR] = err_nxt && !err_r;
  assign ev[netcfg_pkg::EV_MOTION] = moving && !motion_prev_r;
  assign ev[netcfg_pkg::EV_STOPPED] = stop_in && !stop_prev_r && live;
  assign ev[netcfg_pkg::EV_CFG] = (st_r == netcfg_pkg::ST_LATCH);
  assign status_nxt = (rd_status ? '0 : status_r) | ev;

  // Read mux
  wire [31:0] rd_cfg = {20'h00000, cfg_r.node_addr[3:0], 1'b0,
    cfg_r.term_mismatch, cfg_r.term_enable, cfg_r.to_converter,
    cfg_r.range16, cfg_r.baud[2:0]};
  wire [31:0] rd_cmd = {16'h0000, cmd.reverse && go, cmd.forward && go,
    cmd.jog_minus, cmd.jog_plus, cmd.sequential_start, cmd.dsel, 1'b0, cmd.free,
    stop_in, cmd.home, cmd.start, cmd.op_sel};
  wire [31:0] rd_mux =
    !mapped ? netcfg_pkg::RD_UNMAPPED :
    off == netcfg_pkg::OFF_CONFIG ? rd_cfg :
    off == netcfg_pkg::OFF_REMOTE ? {16'h0000, remote_r} :
    off == netcfg_pkg::OFF_CMD ? rd_cmd :
    // Next value, so an event set in the setup cycle is not lost
    off == netcfg_pkg::OFF_STATUS ? {28'h0000000, status_nxt} :
    off == netcfg_pkg::OFF_MASK ? {28'h0000000, mask_r} :
    {31'h00000000, err_r};

  // Init sequence: latch once, then run until next reset
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= netcfg_pkg::ST_RESET;
    end else begin
      case (st_r)
        netcfg_pkg::ST_RESET: st_r <= netcfg_pkg::ST_LATCH;
        netcfg_pkg::ST_LATCH: st_r <= netcfg_pkg::ST_RUN;
        netcfg_pkg::ST_RUN: st_r <= netcfg_pkg::ST_RUN;
        default: st_r <= netcfg_pkg::ST_RESET;
      endcase
    end
  end

  // switches captured only in latch state
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_r <= '0;
    end else if (st_r == netcfg_pkg::ST_LATCH) begin
      cfg_r.to_converter <= !LINK_PARTNER_SELECT;
      cfg_r.node_addr <= ADDRESS_ROTARY_SWITCH;
      cfg_r.range16 <= ADDRESS_RANGE_SELECT;
      cfg_r.baud <= BAUD_RATE_SWITCH;
      cfg_r.term_enable <= TERM_SWITCH_1 && TERM_SWITCH_2;
      cfg_r.term_mismatch <= TERM_SWITCH_1 ^ TERM_SWITCH_2;
    end
  end

  // Register writes
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      remote_r <= netcfg_pkg::REMOTE_RST;
      mask_r <= netcfg_pkg::MASK_RST;
    end else begin
      if (wr_remote) remote_r <= PWDATA[15:0];
      if (wr_mask) mask_r <= PWDATA[netcfg_pkg::NEV-1:0];
    end
  end

  // Status, edge history and divider
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      status_r <= '0;
      err_r <= 1'b0;
      stop_prev_r <= 1'b0;
      motion_prev_r <= 1'b0;
      div_r <= 8'h00;
    end else begin
      status_r <= status_nxt;
      err_r <= err_nxt;
      stop_prev_r <= stop_in;
      motion_prev_r <= moving;
      div_r <= div_nxt;
    end
  end

  // Registered outputs
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      TERM_ENABLE <= 1'b0;
      LINK_ERROR_LED <= 1'b0;
      BAUD_TICK <= 1'b0;
      FORWARD_CONTINUOUS <= 1'b0;
      REVERSE_CONTINUOUS <= 1'b0;
      JOG_PLUS <= 1'b0;
      JOG_MINUS <= 1'b0;
      MOTION_STOP <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      // No wait state: ready in the first access cycle after setup
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !((PADDR[31:8] == 24'h000000) &&
        (off[1:0] == 2'b00) && (off <= netcfg_pkg::OFF_LINKERR));
      PRDATA <= rd_mux;
      TERM_ENABLE <= cfg_r.term_enable;
      LINK_ERROR_LED <= err_nxt;
      BAUD_TICK <= tick;
      FORWARD_CONTINUOUS <= forward_nxt;
      REVERSE_CONTINUOUS <= reverse_nxt;
      JOG_PLUS <= jogp_nxt;
      JOG_MINUS <= jogm_nxt;
      MOTION_STOP <= stop_in || !live;
      IRQ <= |(status_nxt & mask_r);
    end
  end

  // Assertions, all on the one clock, quiet while in reset
  default clocking chk_cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  chk_stop_blocks_motion: assert property (
    $past(stop_in) |->
    !FORWARD_CONTINUOUS && !REVERSE_CONTINUOUS)
    else $error("motion while stop set");
  chk_stop_output: assert property (
    stop_in |=>
    MOTION_STOP)
    else $error("stop output not set");
  chk_fwd_held: assert property (
    go && cmd.forward && !cmd.reverse |=>
    FORWARD_CONTINUOUS)
    else $error("forward not running");
  chk_fwd_release: assert property (
    !cmd.forward |=>
    !FORWARD_CONTINUOUS)
    else $error("forward kept after release");
  chk_dir_excl: assert property (
    !(FORWARD_CONTINUOUS &&
    REVERSE_CONTINUOUS))
    else $error("both directions running");
  chk_rev_held: assert property (
    go && cmd.reverse && !cmd.forward |=>
    REVERSE_CONTINUOUS)
    else $error("reverse not running");
  chk_jogp_held: assert property (
    go && cmd.jog_plus && !cmd.jog_minus |=>
    JOG_PLUS)
    else $error("plus jog not running");
  chk_jog_excl: assert property (
    !(JOG_PLUS &&
    JOG_MINUS))
    else $error("both jog directions on");
  chk_cfg_frozen: assert property (
    st_r == netcfg_pkg::ST_RUN |=>
    $stable(cfg_r))
    else $error("config changed after power-up");
  chk_term_both: assert property (
    st_r == netcfg_pkg::ST_LATCH |=> ##1 TERM_ENABLE ==
    ($past(TERM_SWITCH_1, 2) && $past(TERM_SWITCH_2, 2)))
    else $error("termination decode wrong");
  chk_mismatch_err: assert property (
    live && cfg_r.term_mismatch |=>
    LINK_ERROR_LED)
    else $error("termination mismatch not flagged");
  chk_partner_off: assert property (
    st_r == netcfg_pkg::ST_LATCH |=> cfg_r.to_converter ==
    !$past(LINK_PARTNER_SELECT))
    else $error("partner select wrong");
  chk_no_partner: assert property (
    !cfg_r.to_converter |=> !FORWARD_CONTINUOUS &&
    !REVERSE_CONTINUOUS && !JOG_PLUS && !JOG_MINUS)
    else $error("motion without converter");
  chk_node_addr: assert property (
    st_r == netcfg_pkg::ST_LATCH |=> cfg_r.node_addr ==
    $past(ADDRESS_ROTARY_SWITCH))
    else $error("node address wrong");
  chk_range_latch: assert property (
    st_r == netcfg_pkg::ST_LATCH |=> cfg_r.range16 ==
    $past(ADDRESS_RANGE_SELECT))
    else $error("address range wrong");
  chk_baud_latch: assert property (
    st_r == netcfg_pkg::ST_LATCH |=> cfg_r.baud ==
    $past(BAUD_RATE_SWITCH))
    else $error("baud setting wrong");
  // setting 7 gives tick every 64 cycles
  chk_baud_period: assert property (
    tick && cfg_r.baud == netcfg_pkg::BAUD_CONV |=>
    !tick [*8] ##56 tick)
    else $error("baud tick period wrong");
  // link error lights indicator next cycle
  chk_err_led: assert property (
    LINK_ERROR_IN |=>
    LINK_ERROR_LED)
    else $error("error indicator not lit");
  chk_led_clear: assert property (
    !err_nxt |=>
    !LINK_ERROR_LED)
    else $error("error indicator stuck");
  chk_set_wins: assert property (
    ev[netcfg_pkg::EV_LINKERR] |=>
    status_r[netcfg_pkg::EV_LINKERR])
    else $error("error event lost");
  chk_err_sticky: assert property (
    status_r[netcfg_pkg::EV_LINKERR] && !rd_status |=>
    status_r[netcfg_pkg::EV_LINKERR])
    else $error("error bit dropped");
  chk_irq_level: assert property (
    IRQ ==
    |(status_r & $past(mask_r)))
    else $error("interrupt level wrong");
  // start bit decoded from bit 3
  chk_word_map: assert property (
    rd_cmd[3] == remote_r[3] &&
    rd_cmd[14] == (remote_r[14] && go))
    else $error("remote word decode wrong");
endmodule // network_remote_io_config
`default_nettype wire

//--- conv_model.sv
// Behavioural network converter model on the serial side of the block
`default_nettype none
module conv_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bit_tick,
  input wire logic inject,
  output logic link_err,
  output logic [7:0] tick_gap
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r; // Cycles since last bit enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
      tick_gap <= 8'h00;
    end else if (bit_tick) begin
      tick_gap <= cnt_r + 8'h01;
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  assign link_err = inject;
endmodule // conv_model
`default_nettype wire

//--- tb.sv
// Self-checking bench for the network config block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] e; logic [31:0] m; logic err;} note_t;
  logic CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [31:0] PADDR = 0, PWDATA = 0, PRDATA, r;
  logic PREADY, PSLVERR, LPS = 0, ARS = 1, T1 = 1, T2 = 1, INJ = 0;
  logic [3:0] ROT = 4'h5, BAUD = 4'h7;
  logic TERM, LED, TICK, run_f, run_r, JP, JM, STOP, IRQ, LERR;
  logic [7:0] gap;
  note_t q[$]; // Expected bus answers
  int fails = 0, checked = 0;
  logic [31:0] seed = 32'h52DB42C9;
  logic [15:0] words[6] = '{16'h4000, 16'h8000, 16'h1000, 16'h2000,
    16'hC000, 16'h4020};
  logic [4:0] exp5[6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h00, 5'h01};
  always #12.5 CLK = ~CLK;
  network_remote_io_config DUT (.CLK(CLK), .RST_N(RST_N), .PADDR(PADDR),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .LINK_PARTNER_SELECT(LPS), .ADDRESS_RANGE_SELECT(ARS),
    .ADDRESS_ROTARY_SWITCH(ROT), .BAUD_RATE_SWITCH(BAUD),
    .TERM_SWITCH_1(T1), .TERM_SWITCH_2(T2), .LINK_ERROR_IN(LERR),
    .TERM_ENABLE(TERM), .LINK_ERROR_LED(LED), .BAUD_TICK(TICK),
    .FORWARD_CONTINUOUS(run_f), .REVERSE_CONTINUOUS(run_r), .JOG_PLUS(JP),
    .JOG_MINUS(JM), .MOTION_STOP(STOP), .IRQ(IRQ));
  conv_model PEER (.clk(CLK), .rst_n(RST_N), .bit_tick(TICK),
    .inject(INJ), .link_err(LERR), .tick_gap(gap));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(string n, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // One APB transfer, expectation noted first
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
    logic [31:0] e, logic [31:0] m, logic err);
    int n;
    n = 0;
    q.push_back('{e, m, err});
    @(posedge CLK);
    PSEL <= 1;
    PENABLE <= 0;
    PWRITE <= w;
    PADDR <= {24'h0, a};
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    do @(posedge CLK); while (PREADY !== 1'b1 && n++ < 50);
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  // Compare each completed transfer against oldest note
  always @(posedge CLK) begin
    note_t n;
    if (PSEL && PENABLE && PREADY === 1'b1) begin
      if (q.size() == 0) begin
        n = '{32'h0, 32'h0, 1'b1};
      end else begin
        n = q.pop_front();
      end
      check("prdata", PRDATA & n.m, n.e & n.m);
      check("pslverr", {31'h0, PSLVERR}, {31'h0, n.err});
    end
  end
  task automatic rst();
    RST_N <= 0;
    repeat (2) @(posedge CLK);
    RST_N <= 1;
    repeat (6) @(posedge CLK);
  endtask
  task automatic wr_remote(logic [15:0] w);
    apb(1, netcfg_pkg::OFF_REMOTE, {16'h0, w}, 0, 0, 0);
    repeat (2) @(posedge CLK);
  endtask
  task automatic print_verdict();
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(25 * 30000);
    fails++;
    print_verdict();
  end
  initial begin
    rst();
    apb(0, netcfg_pkg::OFF_CONFIG, 0, 32'h53F, 32'hFFF, 0);
    apb(0, netcfg_pkg::OFF_STATUS, 0, 32'h8, 32'h8, 0);
    check("term", {31'h0, TERM}, 1);
    ROT <= 4'h2;
    BAUD <= 4'h3;
    T2 <= 0;
    LPS <= 1;
    apb(0, netcfg_pkg::OFF_CONFIG, 0, 32'h53F, 32'hFFF, 0);
    check("term", {31'h0, TERM}, 1);
    repeat (400) @(posedge CLK);
    check("gap", {24'h0, gap}, 64);
    wr_remote(16'h4000);
    check("irq", {31'h0, IRQ}, 0);
    apb(1, netcfg_pkg::OFF_MASK, 32'h2, 0, 0, 0);
    apb(0, netcfg_pkg::OFF_MASK, 0, 32'h2, 32'hFFFFFFFF, 0);
    repeat (60) @(posedge CLK);
    check("irq", {31'h0, IRQ}, 1);
    check("fwd", {31'h0, run_f}, 1);
    for (int i = 0; i < 6; i++) begin
      wr_remote(words[i]);
      check("motion", {27'h0, run_f, run_r, JP, JM, STOP}, exp5[i]);
    end
    apb(0, netcfg_pkg::OFF_STATUS, 0, 32'h2, 32'h2, 0);
    @(posedge CLK);
    check("irq", {31'h0, IRQ}, 0);
    repeat (8) begin
      r = xs();
      wr_remote(r[15:0]);
      apb(0, netcfg_pkg::OFF_REMOTE, 0, {16'h0, r[15:0]}, 32'hFFFFFFFF, 0);
      apb(0, netcfg_pkg::OFF_CMD, 0, {16'h0, r[15:0]}, 32'h3F7F, 0);
      check("fwd", {31'h0, run_f}, r[14] & ~r[15] & ~r[5]);
      check("rvs", {31'h0, run_r}, r[15] & ~r[14] & ~r[5]);
      check("stop", {31'h0, STOP}, r[5]);
    end
    INJ <= 1;
    repeat (3) @(posedge CLK);
    check("led", {31'h0, LED}, 1);
    INJ <= 0;
    repeat (3) @(posedge CLK);
    check("led", {31'h0, LED}, 0);
    apb(0, netcfg_pkg::OFF_STATUS, 0, 32'h1, 32'h1, 0);
    apb(0, 8'h18, 0, 0, 32'hFFFFFFFF, 1);
    apb(1, 8'h18, 32'hFFFF, 0, 0, 1);
    rst();
    apb(0, netcfg_pkg::OFF_CONFIG, 0, 32'h24B, 32'hFFF, 0);
    check("term", {31'h0, TERM}, 0);
    wr_remote(16'h4000);
    check("fwd", {31'h0, run_f}, 0);
    repeat (600) @(posedge CLK);
    check("gap", {24'h0, gap}, 255);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
